// ===== ptl_entry_logic.sv
`timescale 1ns/1ps
`include "ptl_defs.svh"
// Functional notes
// - top bit flags contiguous region entry
// - only 64 KiB, level zero, pattern 1000
// - reserved contiguous encodings raise page fault
// - substitute low vpn bits into ppn
// - cache may fill sixteen aliases, walk-start space
// - invalid contiguous entries may be cached
// - walker may skip exact entry read
// - inconsistent overlaps: any translation chosen
// - leaf bits 62:61 override memory attributes
// - decode none, nc memory, io, reserved
// - non-leaf memory type bits set faults
// - leaf memory type three faults
// - misaligned access to io page faults
// - io region typed nc: weak, both classes
// - memory region typed io: strong, both
// - guest stage type forms intermediate attributes
// - first stage type forms final attributes
// - final for two-stage, intermediate for walks
module ptl_entry_logic #(
    parameter int LEVEL_W = 3,
    parameter int ASID_W  = 16,
    parameter int DEPTH   = `PTL_FILL_DEPTH
) (
    // clock and reset
    input  wire logic               i_sys_clk,
    input  wire logic               i_resetn,
    // entry read by the walker
    input  wire logic               i_pte_valid,
    input  wire logic [63:0]        i_pte,
    input  wire logic [LEVEL_W-1:0] i_level,
    input  wire logic [8:0]         i_vpn_at_level,
    input  wire logic [63:0]        i_pte_addr,
    input  wire logic [ASID_W-1:0]  i_walk_asid,
    // stage context
    input  wire logic               i_first_stage,
    input  wire logic               i_guest_mode_on,
    input  wire logic               i_vs_mode_on,
    input  wire logic [1:0]         i_guest_mtype,
    input  wire logic               i_phys_is_io,
    input  wire logic               i_access_misaligned,
    input  wire logic               i_skips_first_stage,
    // interpreted entry
    output logic                    o_res_valid,
    output logic [63:0]             o_res_pte,
    output logic                    o_page_fault,
    output logic                    o_is_leaf,
    output logic                    o_is_contig,
    output logic                    o_attr_io,
    output logic                    o_attr_strong,
    output logic                    o_attr_both_class,
    output logic                    o_inter_io,
    // cache fill stream
    output logic                    o_fill_valid,
    output logic [63:0]             o_fill_addr,
    output logic [63:0]             o_fill_pte,
    output logic [ASID_W-1:0]       o_fill_asid,
    output logic                    o_fill_busy,
    // cache lookup
    input  wire logic [3:0]         i_look_idx,
    output logic [63:0]             o_look_pte
);
    // ------------------------------------------------------------------------
    // region sizing
    // ------------------------------------------------------------------------
    // only the sixteen-page size exists; more sizes would need a size table
    localparam int NB = `PTL_NAPOT_BITS;

    // ------------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------------
    function automatic logic f_is_leaf(input logic [63:0] pte);
        f_is_leaf = pte[`PTL_READ_BIT] | pte[`PTL_WRITE_BIT] | pte[`PTL_EXEC_BIT];
    endfunction

    // override only when the stage is on and the field is nc or io
    function automatic logic f_apply_io(input logic on, input logic [1:0] mt,
                                        input logic base_io);
        if (on && mt == `PTL_MT_IO) begin
            f_apply_io = 1'b1;
        end else if (on && mt == `PTL_MT_NC) begin
            f_apply_io = 1'b0;
        end else begin
            // reserved code passes the base through; a leaf entry faults on it, the guest type does not
            f_apply_io = base_io;
        end
    endfunction

    // ------------------------------------------------------------------------
    // combinational interpretation
    // ------------------------------------------------------------------------
    logic        c_contig;
    logic        c_leaf;
    logic        c_contig_ok;
    logic [1:0]  c_mt;
    logic        c_fault;
    logic [63:0] c_pte;
    logic        c_inter_io;
    logic        c_final_io;
    logic        c_both;

    always_comb begin
        c_contig    = i_pte[`PTL_CONTIG_BIT];
        c_leaf      = f_is_leaf(i_pte);
        c_mt        = i_pte[`PTL_MTYPE_HI:`PTL_MTYPE_LO];
        // only level zero with low ppn pattern 1000 is a legal size
        c_contig_ok = (i_level == '0) &&
                      (i_pte[`PTL_PPN_LO +: NB] == `PTL_NAPOT_PATTERN);
        // faults gathered from every cause, any one is enough
        c_fault     = 1'b0;
        if (c_contig && !c_contig_ok) begin
            c_fault = 1'b1;
        end
        if (!c_leaf && c_mt != `PTL_MT_NONE) begin
            c_fault = 1'b1;
        end
        if (c_leaf && c_mt == `PTL_MT_RSVD) begin
            c_fault = 1'b1;
        end
        // substituted copy; ordinary entries pass untouched
        c_pte = i_pte;
        if (c_contig && c_contig_ok) begin
            c_pte[`PTL_PPN_LO +: NB] = i_vpn_at_level[NB-1:0];
        end
        // two-stage composition: guest stage then first stage
        c_inter_io = f_apply_io(i_guest_mode_on, i_guest_mtype, i_phys_is_io);
        c_final_io = f_apply_io(i_vs_mode_on & c_leaf, c_mt, c_inter_io);
        if (i_skips_first_stage) begin
            c_final_io = c_inter_io;
        end
        // pages whose final class differs from the physical one count as both classes for fences
        c_both = c_final_io != i_phys_is_io;
        // io-typed pages reject misaligned accesses
        if (c_leaf && c_final_io && i_access_misaligned) begin
            c_fault = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // result registers
    // ------------------------------------------------------------------------
    logic        res_valid, next_res_valid;
    logic [63:0] res_pte,   next_res_pte;
    logic        res_fault, next_res_fault;
    logic        res_leaf,  next_res_leaf;
    logic        res_cont,  next_res_cont;
    logic        res_io,    next_res_io;
    logic        res_both,  next_res_both;
    logic        res_iio,   next_res_iio;

    // hold the last result until the next entry arrives
    always_comb begin
        next_res_valid = i_pte_valid;
        next_res_pte   = res_pte;
        next_res_fault = res_fault;
        next_res_leaf  = res_leaf;
        next_res_cont  = res_cont;
        next_res_io    = res_io;
        next_res_both  = res_both;
        next_res_iio   = res_iio;
        // fault and attributes only change with a new entry
        if (i_pte_valid) begin
            next_res_pte   = c_pte;
            next_res_fault = c_fault;
            next_res_leaf  = c_leaf;
            next_res_cont  = c_contig & c_contig_ok;
            next_res_io    = c_final_io;
            next_res_both  = c_both;
            next_res_iio   = c_inter_io;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            res_valid <= 1'b0;
            res_pte   <= '0;
            res_fault <= 1'b0;
            res_leaf  <= 1'b0;
            res_cont  <= 1'b0;
            res_io    <= 1'b0;
            res_both  <= 1'b0;
            res_iio   <= 1'b0;
        end else begin
            res_valid <= next_res_valid;
            res_pte   <= next_res_pte;
            res_fault <= next_res_fault;
            res_leaf  <= next_res_leaf;
            res_cont  <= next_res_cont;
            res_io    <= next_res_io;
            res_both  <= next_res_both;
            res_iio   <= next_res_iio;
        end
    end

    // ------------------------------------------------------------------------
    // result outputs
    // ------------------------------------------------------------------------
    // strong ordering simply follows the final io class
    assign o_res_valid       = res_valid;
    assign o_res_pte         = res_pte;
    assign o_page_fault      = res_fault;
    assign o_is_leaf         = res_leaf;
    assign o_is_contig       = res_cont;
    assign o_attr_io         = res_io;
    assign o_attr_strong     = res_io;
    assign o_attr_both_class = res_both;
    assign o_inter_io        = res_iio;

    // ------------------------------------------------------------------------
    // alias filler: one cache entry per cycle across the region
    // ------------------------------------------------------------------------
    ptl_pkg::ptl_state_t st, next_st;
    logic [NB-1:0]       j, next_j;
    logic [63:0]         faddr, next_faddr;
    logic [63:0]         fpte, next_fpte;
    logic [ASID_W-1:0]   fasid, next_fasid;

    // invalid-bit entries are filled too; faulting ones are not
    always_comb begin
        next_st    = st;
        next_j     = j;
        next_faddr = faddr;
        next_fpte  = fpte;
        next_fasid = fasid;
        case (st)
            ptl_pkg::PTL_IDLE: begin
                // a fault or a wrong size never starts the filler
                if (i_pte_valid && c_contig && c_contig_ok && !c_fault) begin
                    next_st    = ptl_pkg::PTL_FILL;
                    next_j     = '0;
                    // first alias address: entry address minus low vpn bits times entry size
                    next_faddr = i_pte_addr - 64'(i_vpn_at_level[NB-1:0]) *
                                 64'(`PTL_ENTRY_SIZE);
                    next_fpte  = c_pte;
                    next_fasid = i_walk_asid;
                end
            end
            ptl_pkg::PTL_FILL: begin
                // one alias per cycle, address stepped by one entry
                next_j     = j + 1'b1;
                next_faddr = faddr + 64'(`PTL_ENTRY_SIZE);
                if (j == '1) begin
                    next_st = ptl_pkg::PTL_DONE;
                end
            end
            ptl_pkg::PTL_DONE: begin
                // one quiet cycle before the filler takes a new region
                next_st = ptl_pkg::PTL_IDLE;
            end
            default: begin
                next_st = ptl_pkg::PTL_IDLE;
            end
        endcase
    end

    // filler state, address and copy registered together
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            st    <= ptl_pkg::PTL_IDLE;
            j     <= '0;
            faddr <= '0;
            fpte  <= '0;
            fasid <= '0;
        end else begin
            st    <= next_st;
            j     <= next_j;
            faddr <= next_faddr;
            fpte  <= next_fpte;
            fasid <= next_fasid;
        end
    end

    // ------------------------------------------------------------------------
    // fill stream outputs
    // ------------------------------------------------------------------------
    // filled copies all share one substituted pte; the walker never re-reads
    // the aliased entries, so their accessed/dirty bits may diverge
    assign o_fill_valid = (st == ptl_pkg::PTL_FILL);
    assign o_fill_addr  = faddr;
    assign o_fill_pte   = fpte;
    assign o_fill_asid  = fasid;
    assign o_fill_busy  = (st != ptl_pkg::PTL_IDLE);

    // ------------------------------------------------------------------------
    // alias storage
    // ------------------------------------------------------------------------
    // lookups see a fresh copy one cycle after its write
    // last writer wins on overlapping aliases; no ordering promised
    ptl_fill_mem #(
        .WIDTH (64),
        .DEPTH (DEPTH),
        .AW    (NB)
    ) u_mem (
        .i_sys_clk (i_sys_clk),
        .i_wr_en   (o_fill_valid),
        .i_wr_addr (j),
        .i_wr_data (fpte),
        .i_rd_addr (i_look_idx),
        .o_rd_data (o_look_pte)
    );
endmodule

// ===== ptl_defs.svh
`ifndef PTL_DEFS_SVH
`define PTL_DEFS_SVH

// ----------------------------------------------------------------------------
// entry layout
// ----------------------------------------------------------------------------
`define PTL_CONTIG_BIT      63
`define PTL_MTYPE_HI        62
`define PTL_MTYPE_LO        61
`define PTL_PPN_LO          10
`define PTL_VPN_W           9
`define PTL_FLAGS_W         6
`define PTL_READ_BIT        1
`define PTL_WRITE_BIT       2
`define PTL_EXEC_BIT        3
// ----------------------------------------------------------------------------
// contiguous region encoding
// ----------------------------------------------------------------------------
`define PTL_NAPOT_BITS      4
`define PTL_NAPOT_PATTERN   4'h8
`define PTL_ENTRY_SIZE      8
// ----------------------------------------------------------------------------
// memory type codes
// ----------------------------------------------------------------------------
`define PTL_MT_NONE         2'h0
`define PTL_MT_NC           2'h1
`define PTL_MT_IO           2'h2
`define PTL_MT_RSVD         2'h3
`define PTL_FILL_DEPTH      16

`endif

// ===== ptl_pkg.sv
package ptl_pkg;
    // memory type field values
    typedef enum logic [1:0] {
        PTL_MT_NONE_E = 2'h0,
        PTL_MT_NC_E   = 2'h1,
        PTL_MT_IO_E   = 2'h2,
        PTL_MT_RSV_E  = 2'h3
    } ptl_mtype_t;

    // filler state machine, one-hot
    typedef enum logic [2:0] {
        PTL_IDLE = 3'b001,
        PTL_FILL = 3'b010,
        PTL_DONE = 3'b100
    } ptl_state_t;
endpackage

// ===== ptl_fill_mem.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// small translation cache storage, registered read data
// ----------------------------------------------------------------------------
module ptl_fill_mem #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // clock
    input  wire logic             i_sys_clk,
    // write port
    input  wire logic             i_wr_en,
    input  wire logic [AW-1:0]    i_wr_addr,
    input  wire logic [WIDTH-1:0] i_wr_data,
    // read port
    input  wire logic [AW-1:0]    i_rd_addr,
    output logic      [WIDTH-1:0] o_rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rd_data;

    // storage carries no reset; valid state lives with the owner
    always_ff @(posedge i_sys_clk) begin
        if (i_wr_en) begin
            mem[i_wr_addr] <= i_wr_data;
        end
        rd_data <= mem[i_rd_addr];
    end
    assign o_rd_data = rd_data;
endmodule

// ===== ptl_chk_properties.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// entry interpretation properties at the top ports
// ----------------------------------------------------------------------------
module ptl_chk #(
    parameter int LEVEL_W = 3
) (
    // clock and reset
    input  wire logic               i_sys_clk,
    input  wire logic               i_resetn,
    // entry and context
    input  wire logic               i_pte_valid,
    input  wire logic [63:0]        i_pte,
    input  wire logic [LEVEL_W-1:0] i_level,
    input  wire logic [8:0]         i_vpn_at_level,
    input  wire logic               i_guest_mode_on,
    input  wire logic               i_vs_mode_on,
    input  wire logic               i_phys_is_io,
    input  wire logic               i_access_misaligned,
    input  wire logic               i_skips_first_stage,
    // results
    input  wire logic [63:0]        o_res_pte,
    input  wire logic               o_page_fault,
    input  wire logic               o_attr_io,
    input  wire logic               o_attr_strong,
    input  wire logic               o_attr_both_class,
    input  wire logic               o_inter_io,
    input  wire logic               o_fill_valid,
    input  wire logic [63:0]        o_fill_addr,
    input  wire logic               o_fill_busy
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    // decoded views of the presented entry
    wire       leaf = |i_pte[3:1];
    wire [1:0] mt   = i_pte[62:61];
    wire       nap  = i_pte_valid && i_pte[63];
    wire       good = nap && i_level == '0 && i_pte[13:10] == 4'h8;
    wire       ctx  = i_pte_valid && leaf && i_vs_mode_on && !i_skips_first_stage;
    // sixteen fill cycles, split in halves to keep the unroll small
    sequence s_half;
        o_fill_valid [* 8];
    endsequence
    property p_subst;
        good |=> o_res_pte[13:10] == $past(i_vpn_at_level[3:0])
            && o_res_pte[63:14] == $past(i_pte[63:14]);
    endproperty
    a_subst: assert property (p_subst) else $error("bad substitution");
    property p_rsvd;
        nap && !good |=> o_page_fault;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved region kept");
    property p_nonleaf;
        i_pte_valid && !leaf && mt != 2'h0 |=> o_page_fault;
    endproperty
    a_nonleaf: assert property (p_nonleaf) else $error("non-leaf type kept");
    property p_mt3;
        i_pte_valid && leaf && mt == 2'h3 |=> o_page_fault;
    endproperty
    a_mt3: assert property (p_mt3) else $error("type three kept");
    property p_fill;
        good && leaf && mt == 2'h0 && !i_access_misaligned && !o_fill_busy
            |=> s_half ##1 s_half ##1 (!o_fill_valid && o_fill_busy) ##1 !o_fill_busy;
    endproperty
    a_fill: assert property (p_fill) else $error("fill length wrong");
    property p_step;
        o_fill_valid && $past(o_fill_valid) |-> o_fill_addr == $past(o_fill_addr) + 64'h8;
    endproperty
    a_step: assert property (p_step) else $error("fill address step");
    property p_io;
        ctx && mt == 2'h2 && !i_access_misaligned |=> o_attr_io && o_attr_strong;
    endproperty
    a_io: assert property (p_io) else $error("io type not applied");
    property p_nc;
        ctx && mt == 2'h1 && !i_guest_mode_on
            |=> !o_attr_io && o_attr_both_class == $past(i_phys_is_io);
    endproperty
    a_nc: assert property (p_nc) else $error("nc type not applied");
    property p_inter;
        i_pte_valid && leaf && mt != 2'h3 && !i_guest_mode_on |=> o_inter_io == $past(i_phys_is_io);
    endproperty
    a_inter: assert property (p_inter) else $error("intermediate wrong");
    property p_skip;
        i_pte_valid && leaf && mt != 2'h3 && i_skips_first_stage |=> o_attr_io == o_inter_io;
    endproperty
    a_skip: assert property (p_skip) else $error("skip attributes wrong");
endmodule

bind ptl_entry_logic ptl_chk #(.LEVEL_W(LEVEL_W)) u_chk (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_pte_valid(i_pte_valid), .i_pte(i_pte),
    .i_level(i_level), .i_vpn_at_level(i_vpn_at_level), .i_guest_mode_on(i_guest_mode_on),
    .i_vs_mode_on(i_vs_mode_on), .i_phys_is_io(i_phys_is_io),
    .i_access_misaligned(i_access_misaligned), .i_skips_first_stage(i_skips_first_stage),
    .o_res_pte(o_res_pte), .o_page_fault(o_page_fault), .o_attr_io(o_attr_io),
    .o_attr_strong(o_attr_strong), .o_attr_both_class(o_attr_both_class),
    .o_inter_io(o_inter_io), .o_fill_valid(o_fill_valid), .o_fill_addr(o_fill_addr),
    .o_fill_busy(o_fill_busy)
);

// ===== ptl_pt_mem.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// page-table word addressed by the walker
// ----------------------------------------------------------------------------
module ptl_pt_mem (
    // clock
    input  wire logic        i_sys_clk,
    // load side
    input  wire logic        i_wr,
    input  wire logic [63:0] i_wr_pte,
    // read side
    input  wire logic        i_rd_en,
    output logic      [63:0] o_pte
);
    logic [63:0] word;
    // the word lands at the edge after the load
    always_ff @(posedge i_sys_clk) begin
        if (i_wr) begin
            word <= i_wr_pte;
        end
    end
    // an idle bus shows the inverse, so a stale entry can never match
    assign o_pte = i_rd_en ? word : ~word;
endmodule

// ===== test_napot_memtype_pte_logic.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// entry interpretation bench
// ----------------------------------------------------------------------------
module test_napot_memtype_pte_logic;
    logic i_sys_clk, i_resetn, i_pte_valid, i_first_stage, i_guest_mode_on, i_vs_mode_on;
    logic i_phys_is_io, i_access_misaligned, i_skips_first_stage, wr, ren;
    logic o_res_valid, o_page_fault, o_is_leaf, o_is_contig, o_attr_io, o_attr_strong;
    logic o_attr_both_class, o_inter_io, o_fill_valid, o_fill_busy;
    logic [1:0]  i_guest_mtype;
    logic [2:0]  i_level;
    logic [3:0]  i_look_idx;
    logic [8:0]  i_vpn_at_level;
    logic [15:0] i_walk_asid, o_fill_asid;
    logic [63:0] i_pte, i_pte_addr, wpte, o_res_pte, o_fill_addr, o_fill_pte, o_look_pte;
    int          failures;
    int          compares;
    ptl_entry_logic dut (
        .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_pte_valid(i_pte_valid),
        .i_pte(i_pte), .i_level(i_level), .i_vpn_at_level(i_vpn_at_level),
        .i_pte_addr(i_pte_addr), .i_walk_asid(i_walk_asid),
        .i_first_stage(i_first_stage), .i_guest_mode_on(i_guest_mode_on),
        .i_vs_mode_on(i_vs_mode_on), .i_guest_mtype(i_guest_mtype),
        .i_phys_is_io(i_phys_is_io), .i_access_misaligned(i_access_misaligned),
        .i_skips_first_stage(i_skips_first_stage), .o_res_valid(o_res_valid),
        .o_res_pte(o_res_pte), .o_page_fault(o_page_fault), .o_is_leaf(o_is_leaf),
        .o_is_contig(o_is_contig), .o_attr_io(o_attr_io), .o_attr_strong(o_attr_strong),
        .o_attr_both_class(o_attr_both_class), .o_inter_io(o_inter_io),
        .o_fill_valid(o_fill_valid), .o_fill_addr(o_fill_addr), .o_fill_pte(o_fill_pte),
        .o_fill_asid(o_fill_asid), .o_fill_busy(o_fill_busy), .i_look_idx(i_look_idx),
        .o_look_pte(o_look_pte)
    );
    ptl_pt_mem u_mem (.i_sys_clk(i_sys_clk), .i_wr(wr), .i_wr_pte(wpte), .i_rd_en(ren),
                      .o_pte(i_pte));
    // core clock, 8 ns period
    always #4 i_sys_clk = ~i_sys_clk;
    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    task automatic report_and_stop();
        if (failures == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask
    // load the table word, let the walker take it, land on the result cycle
    task automatic ent(input logic [63:0] e, input logic [2:0] l);
        @(negedge i_sys_clk);
        wr = 1'b1;
        wpte = e;
        @(negedge i_sys_clk);
        wr = 1'b0;
        ren = 1'b1;
        i_pte_valid = 1'b1;
        i_level = l;
        @(negedge i_sys_clk);
        ren = 1'b0;
        i_pte_valid = 1'b0;
        chk(64'(o_res_valid), 64'h1);
    endtask
    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic t_napot();
        ent(64'h8000_0000_0048_e0cb, 3'h0);
        chk(o_res_pte, 64'h8000_0000_0048_e8cb);
        chk(64'({o_page_fault, o_is_contig}), 64'h1);
        for (int j = 0; j < 16; j++) begin
            chk(o_fill_addr, 64'h0000_0000_8000_1000 + 64'(j * 8));
            chk({o_fill_pte[63:14], 4'h0, o_fill_pte[9:0]}, 64'h8000_0000_0048_c0cb);
            chk({47'h0, o_fill_valid, o_fill_asid}, 64'h0001_0a5c);
            @(negedge i_sys_clk);
        end
        chk(64'({o_fill_valid, o_fill_busy}), 64'h1);
        i_look_idx = 4'h5;
        @(negedge i_sys_clk);
        chk(64'(o_fill_busy), 64'h0);
        chk({o_look_pte[63:14], 4'h0, o_look_pte[9:0]}, 64'h8000_0000_0048_c0cb);
        // a clear valid bit still fills; a mid-fill reset drops the fill
        ent(64'h8000_0000_0048_e0ca, 3'h0);
        chk(64'({o_page_fault, o_is_contig, o_fill_valid}), 64'h3);
        i_resetn = 1'b0;
        @(negedge i_sys_clk);
        chk(64'({o_fill_busy, o_res_valid, o_is_contig, o_page_fault}), 64'h0);
        chk(o_res_pte, 64'h0);
        i_resetn = 1'b1;
    endtask
    task automatic t_rsvd();
        // low bit set, bit three clear, level one
        ent(64'h8000_0000_0048_e4cb, 3'h0);
        chk(64'({o_page_fault, o_fill_valid}), 64'h2);
        ent(64'h8000_0000_0048_c0cb, 3'h0);
        chk(64'({o_page_fault, o_fill_valid}), 64'h2);
        ent(64'h8000_0000_0048_e0cb, 3'h1);
        chk(64'({o_page_fault, o_fill_valid}), 64'h2);
    endtask
    task automatic t_mtype();
        i_vs_mode_on = 1'b1;
        for (int t = 0; t < 4; t++) begin
            ent(64'h0000_0000_0048_e0cb | (64'(t) << 61), 3'h0);
            chk(64'({o_page_fault, o_attr_io}), {62'h0, t == 3, t == 2});
        end
        ent(64'h2000_0000_0048_e001, 3'h1);
        chk(64'({o_page_fault, o_is_leaf}), 64'h2);
        ent(64'h0000_0000_0048_e001, 3'h1);
        chk(64'({o_page_fault, o_is_leaf}), 64'h0);
    endtask
    task automatic t_order();
        i_phys_is_io = 1'b1;
        ent(64'h2000_0000_0048_e0cb, 3'h0);
        chk(64'({o_attr_io, o_attr_both_class}), 64'h1);
        i_phys_is_io = 1'b0;
        ent(64'h4000_0000_0048_e0cb, 3'h0);
        chk(64'({o_attr_io, o_attr_strong, o_attr_both_class}), 64'h7);
        i_access_misaligned = 1'b1;
        ent(64'h4000_0000_0048_e0cb, 3'h0);
        chk(64'(o_page_fault), 64'h1);
        i_access_misaligned = 1'b0;
    endtask
    task automatic t_stage();
        i_guest_mode_on = 1'b1;
        i_guest_mtype = 2'h2;
        i_vs_mode_on = 1'b0;
        ent(64'h2000_0000_0048_e0cb, 3'h0);
        chk(64'({o_inter_io, o_attr_io}), 64'h3);
        i_vs_mode_on = 1'b1;
        ent(64'h2000_0000_0048_e0cb, 3'h0);
        chk(64'({o_inter_io, o_attr_io}), 64'h2);
        i_skips_first_stage = 1'b1;
        ent(64'h2000_0000_0048_e0cb, 3'h0);
        chk(64'(o_attr_io), 64'h1);
    endtask
    // main sequence, reset held three cycles
    initial begin
        i_sys_clk = 1'b0;
        {i_resetn, i_pte_valid, i_first_stage, i_guest_mode_on, i_vs_mode_on} = '0;
        {i_phys_is_io, i_access_misaligned, i_skips_first_stage, wr, ren} = '0;
        {i_guest_mtype, i_level, i_look_idx} = '0;
        i_vpn_at_level = 9'h15a;
        i_walk_asid = 16'h0a5c;
        i_pte_addr = 64'h0000_0000_8000_1050;
        wpte = '0;
        failures = 0;
        compares = 0;
        repeat (3) @(negedge i_sys_clk);
        i_resetn = 1'b1;
        t_napot();
        t_rsvd();
        t_mtype();
        t_order();
        t_stage();
        report_and_stop();
    end
    // watchdog, far beyond the roughly 72 cycles the scenarios need
    initial begin
        #24000;
        failures++;
        report_and_stop();
    end
endmodule
